// >>> pkg/ebac_pkg.sv
// Purpose: constants and types shared by the byte access controller
// Assumes: cpu clock at 10 MHz, write timebase from a 1 MHz oscillator tick
// Notes:   i/o register indices are local choices
package ebac_pkg;
	localparam int          ADDR_W         = 10;
	localparam int          DEPTH          = 1024;
	localparam logic [1:0]  IDX_ADDR_HIGH  = 2'h0;
	localparam logic [1:0]  IDX_ADDR_LOW   = 2'h1;
	localparam logic [1:0]  IDX_DATA       = 2'h2;
	localparam logic [1:0]  IDX_CONTROL    = 2'h3;
	localparam int          BIT_RIE        = 3;
	localparam int          BIT_MWE        = 2;
	localparam int          BIT_WS         = 1;
	localparam int          BIT_RS         = 0;
	localparam logic [7:0]  DATA_RESET     = 8'h00;
	localparam int          MWE_WINDOW     = 4;
	localparam int          WRITE_STALL    = 2;
	localparam int          READ_STALL     = 4;
	localparam int          WRITE_OSC_CYC  = 8448;
	localparam int          CLK_HZ         = 10_000_000;
	localparam int          OSC_HZ         = 1_000_000;
	localparam int          OSC_DIV        = CLK_HZ / OSC_HZ;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] idx;
		logic [7:0] wdata;
	} ebac_io_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_DONE  = 2'b11
	} ebac_state_t;
endpackage

// >>> hw/ebac_down_counter.sv
// Purpose: loadable down counter with a zero flag
// Assumes: load wins over count
// Notes:   used for stall, window and oscillator timing
module ebac_down_counter #(
	parameter int W = 14
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	input  wire logic         step,
	output logic [W-1:0]      count,
	output logic              zero
);
	logic [W-1:0] next_count;

	if (W < 2) begin : g_width_check
		$error("ebac_down_counter: width too small");
	end

	always_comb begin
		next_count = count;
		if (load) begin
			next_count = value;
		end else if (step && count != '0) begin
			next_count = count - W'(1);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign zero = (count == '0);
endmodule

// >>> hw/ebac_ctrl.sv
// Purpose: cpu byte access to a 1024 byte nonvolatile array through four i/o registers
// Assumes: one i/o strobe per cycle; osc_tick pulses at 1 MHz from another clock
// Notes:   array modelled as a register array; writes commit at the end of the timed write
module ebac_ctrl
	import ebac_pkg::*;
#(
	parameter int WRITE_TICKS = WRITE_OSC_CYC
) (
	input  wire logic            clock,
	input  wire logic            sys_rst,
	input  wire ebac_pkg::ebac_io_t io,
	input  wire logic            global_irq_enable,
	input  wire logic            flash_selfprog_enable,
	input  wire logic            osc_tick,
	output logic [7:0]           rdata,
	output logic                 cpu_stall,
	output logic                 ready_irq
);
	import ebac_pkg::*;

	if (WRITE_TICKS < 1 || WRITE_TICKS > 16383) begin : g_ticks_check
		$error("ebac_ctrl: WRITE_TICKS out of range");
	end

	// ------------------------------------------------------------
	// storage and registers
	// ------------------------------------------------------------
	logic [7:0]        mem [DEPTH];
	logic [ADDR_W-1:0] byte_address_reg, next_addr;
	logic [7:0]        byte_data_reg, next_data;
	logic              ready_irq_enable, next_rie;
	logic              master_write_enable, next_mwe;
	logic              write_strobe, next_ws;
	ebac_state_t       state, next_state;
	logic [ADDR_W-1:0] wr_addr, next_wr_addr;
	logic [7:0]        wr_byte, next_wr_byte;
	logic              commit;
	logic [7:0]        next_rdata;
	logic              next_irq;

	// tick synchroniser: first stage read only by second
	// not reset: a reset in mid-write must not fake or drop a tick
	logic tick_s1, tick_s2, tick_s3;
	always_ff @(posedge clock) begin
		tick_s1 <= osc_tick;
		tick_s2 <= tick_s1;
		tick_s3 <= tick_s2;
	end
	wire tick_rise = tick_s2 & ~tick_s3;

	// ------------------------------------------------------------
	// control decode
	// ------------------------------------------------------------
	wire ctl_wr   = io.wr && io.idx == IDX_CONTROL;
	// done state still shows the strobe, so it counts as busy
	wire busy     = (state != ST_IDLE);
	wire mwe_win;
	wire stall_zero;
	wire time_zero;
	wire [3:0]  stall_cnt;
	wire [13:0] time_cnt;
	wire [3:0]  win_cnt;
	// strobe written with master already open; both in one write does not count
	wire start_wr = ctl_wr && io.wdata[BIT_WS] && master_write_enable && !busy
		&& !flash_selfprog_enable;
	wire start_rd = ctl_wr && io.wdata[BIT_RS] && !busy;
	// a set in the expiry cycle reopens the window: set wins over clear
	wire mwe_set  = ctl_wr && io.wdata[BIT_MWE] && !(master_write_enable && mwe_win);

	ebac_down_counter #(.W(4)) u_window (
		.clock   (clock),
		.sys_rst (sys_rst),
		.load    (mwe_set),
		.value   (4'(MWE_WINDOW)),
		.step    (1'b1),
		.count   (win_cnt),
		.zero    ()
	);
	assign mwe_win = (win_cnt != 4'h0);

	ebac_down_counter #(.W(4)) u_stall (
		.clock   (clock),
		.sys_rst (sys_rst),
		.load    (start_wr || start_rd),
		.value   (start_rd ? 4'(READ_STALL) : 4'(WRITE_STALL)),
		.step    (1'b1),
		.count   (stall_cnt),
		.zero    (stall_zero)
	);

	ebac_down_counter #(.W(14)) u_wtime (
		.clock   (clock),
		.sys_rst (1'b0),
		.load    (start_wr),
		.value   (14'(WRITE_TICKS)),
		.step    (tick_rise),
		.count   (time_cnt),
		.zero    (time_zero)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_addr    = byte_address_reg;
		next_data    = byte_data_reg;
		next_rie     = ready_irq_enable;
		next_mwe     = master_write_enable;
		next_ws      = write_strobe;
		next_state   = state;
		next_wr_addr = wr_addr;
		next_wr_byte = wr_byte;
		commit       = 1'b0;
		if (io.wr && !busy && io.idx == IDX_ADDR_HIGH)
			next_addr[ADDR_W-1:8] = io.wdata[ADDR_W-9:0];
		if (io.wr && !busy && io.idx == IDX_ADDR_LOW)
			next_addr[7:0] = io.wdata;
		if (io.wr && io.idx == IDX_DATA)
			next_data = io.wdata;
		if (ctl_wr) begin
			next_rie = io.wdata[BIT_RIE];
			if (io.wdata[BIT_MWE])
				next_mwe = 1'b1;
		end
		if (master_write_enable && !mwe_win && !mwe_set)
			next_mwe = 1'b0;
		if (start_rd)
			next_data = mem[byte_address_reg];
		case (state)
			ST_IDLE: begin
				if (start_wr) begin
					next_ws      = 1'b1;
					next_wr_addr = byte_address_reg;
					next_wr_byte = byte_data_reg;
					next_state   = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (time_zero && stall_zero) begin
					commit     = 1'b1;
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_ws    = 1'b0;
				next_state = ST_IDLE;
			end
			// unknown power-up state settles here with the strobe clear
			default: begin
				next_ws    = 1'b0;
				next_state = ST_IDLE;
			end
		endcase
		next_rdata = 8'h00;
		case (io.idx)
			IDX_ADDR_HIGH: next_rdata = {{(16-ADDR_W){1'b0}}, next_addr[ADDR_W-1:8]};
			IDX_ADDR_LOW:  next_rdata = next_addr[7:0];
			IDX_DATA:      next_rdata = next_data;
			IDX_CONTROL:   next_rdata = {4'h0, next_rie, next_mwe, next_ws, 1'b0};
			default:       next_rdata = 8'h00;
		endcase
		next_irq = next_rie && global_irq_enable && !next_ws;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		byte_address_reg <= next_addr;
		wr_addr          <= next_wr_addr;
		wr_byte          <= next_wr_byte;
		if (commit)
			mem[wr_addr] <= wr_byte;
	end

	// write progress is kept across reset so a started write finishes
	always_ff @(posedge clock) begin
		state        <= next_state;
		write_strobe <= next_ws;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			byte_data_reg       <= DATA_RESET;
			ready_irq_enable    <= 1'b0;
			master_write_enable <= 1'b0;
			rdata               <= 8'h00;
			cpu_stall           <= 1'b0;
			ready_irq           <= 1'b0;
		end else begin
			byte_data_reg       <= next_data;
			ready_irq_enable    <= next_rie;
			master_write_enable <= next_mwe;
			rdata               <= next_rdata;
			cpu_stall           <= (start_wr || start_rd) || stall_cnt > 4'h1;
			ready_irq           <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_both_bits_nostart: assert property (@(posedge clock) disable iff (sys_rst)
		(ctl_wr && io.wdata[BIT_WS] && !master_write_enable && !write_strobe) |=> !write_strobe)
		else $error("write started without prior master enable");
	a_mwe_self_clear: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(master_write_enable) |-> ##[1:5] !master_write_enable)
		else $error("master enable did not self clear");
	a_write_stall_two: assert property (@(posedge clock) disable iff (sys_rst)
		start_wr |=> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
		else $error("write stall not two cycles");
	a_read_stall_four: assert property (@(posedge clock) disable iff (sys_rst)
		start_rd |=> cpu_stall [*4] ##1 !cpu_stall)
		else $error("read stall not four cycles");
	a_read_fetch_now: assert property (@(posedge clock) disable iff (sys_rst)
		start_rd |=> byte_data_reg == mem[$past(byte_address_reg)])
		else $error("read byte not fetched");
	a_addr_frozen: assert property (@(posedge clock) disable iff (sys_rst)
		busy |=> byte_address_reg == $past(byte_address_reg))
		else $error("address changed during write");
	a_strobe_held: assert property (@(posedge clock) disable iff (sys_rst)
		start_wr |=> write_strobe [*8])
		else $error("write strobe dropped early");
	a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
		ready_irq == (ready_irq_enable && $past(global_irq_enable) && !write_strobe))
		else $error("ready interrupt level wrong");
	a_no_flash_start: assert property (@(posedge clock) disable iff (sys_rst)
		(flash_selfprog_enable && !write_strobe) |=> !write_strobe)
		else $error("write started during flash programming");
	c_write: cover property (@(posedge clock) disable iff (sys_rst) start_wr);
	c_read: cover property (@(posedge clock) disable iff (sys_rst) start_rd);
	c_timeout: cover property (@(posedge clock) disable iff (sys_rst) $fell(master_write_enable));
	c_done: cover property (@(posedge clock) disable iff (sys_rst) commit);
endmodule

// >>> verif/ebac_cpu_model.sv
// Purpose: software stand-in driving the i/o register strobes
// Assumes: one access per call, driven on the falling clock edge
// Notes:   rdata is taken one clock cycle after the index is presented
module ebac_cpu_model (
	input  wire logic          clock,
	input  wire logic [7:0]    rdata,
	output ebac_pkg::ebac_io_t io
);
	timeunit 1ns;
	timeprecision 1ns;
	import ebac_pkg::*;

	initial io = '0;

	// ----------------
	// i/o accesses
	// ----------------
	// idle cycle between strobes keeps wr a one-cycle pulse
	task automatic wr(input logic [1:0] idx, input logic [7:0] d);
		@(negedge clock);
		io <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
		@(negedge clock);
		io.wr <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] idx, output logic [7:0] d);
		@(negedge clock);
		io <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 8'h00};
		@(negedge clock);
		d = rdata;
		io.rd <= 1'b0;
	endtask
endmodule

// >>> verif/tb_ebac_ctrl.sv
// Purpose: self-checking bench for the byte access controller
// Assumes: write time shortened to 4 oscillator ticks
// Notes:   expected bytes come from a local array, never from the design
module tb_ebac_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import ebac_pkg::*;

	localparam int WT = 4;
	logic       clock, sys_rst, global_irq_enable, flash_selfprog_enable, osc_tick;
	ebac_io_t   io;
	logic [7:0] rdata, v, d;
	logic       cpu_stall, ready_irq;
	logic [7:0] mem [DEPTH];
	logic [9:0] al [8];
	int         bad_count, checks_done, n;

	ebac_ctrl #(.WRITE_TICKS(WT)) dut (.clock(clock), .sys_rst(sys_rst), .io(io),
		.global_irq_enable(global_irq_enable), .flash_selfprog_enable(flash_selfprog_enable),
		.osc_tick(osc_tick), .rdata(rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
	ebac_cpu_model cpu (.clock(clock), .rdata(rdata), .io(io));

	// ----------------
	// clocks
	// ----------------
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	// odd offset so ticks never line up with the cpu clock
	initial begin
		osc_tick = 0;
		#37;
		forever #500 osc_tick = ~osc_tick;
	end

	// ----------------
	// tasks
	// ----------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// the stall starts at the edge that takes the strobe: count it too
	task automatic stalls(output int k);
		k = (cpu_stall === 1'b1) ? 1 : 0;
		repeat (6) begin
			@(negedge clock);
			if (cpu_stall === 1'b1) k++;
		end
	endtask

	task automatic arm(input logic [7:0] x);
		cpu.wr(IDX_CONTROL, x | 8'h04);
		cpu.wr(IDX_CONTROL, x | 8'h06);
	endtask

	task automatic wait_idle(output int k);
		k = 6;
		do begin
			cpu.rd(IDX_CONTROL, v);
			k += 2;
		end while (v[BIT_WS] !== 1'b0 && k < 2000);
		check("idle", 8'(k < 2000), 8'h01);
	endtask

	task automatic set_addr(input logic [9:0] a);
		cpu.wr(IDX_ADDR_HIGH, {6'h00, a[9:8]});
		cpu.wr(IDX_ADDR_LOW, a[7:0]);
	endtask

	task automatic write_byte(input logic [9:0] a, input logic [7:0] x);
		set_addr(a);
		cpu.wr(IDX_DATA, x);
		arm(8'h00);
		stalls(n);
		check("wstall", n[7:0], 8'h02);
		wait_idle(n);
		check("wdur", 8'(n >= (WT-1)*OSC_DIV && n <= (WT+1)*OSC_DIV+8), 8'h01);
		mem[a] = x;
	endtask

	task automatic read_byte(input logic [9:0] a);
		set_addr(a);
		cpu.wr(IDX_DATA, ~mem[a]);
		cpu.wr(IDX_CONTROL, 8'h01);
		stalls(n);
		check("rstall", n[7:0], 8'h04);
		cpu.rd(IDX_DATA, v);
		check("rbyte", v, mem[a]);
	endtask

	task automatic refused();
		stalls(n);
		check("nostall", n[7:0], 8'h00);
		cpu.rd(IDX_CONTROL, v);
		check("nostart", v & 8'h02, 8'h00);
	endtask

	// ----------------
	// sequence
	// ----------------
	initial begin
		bad_count = 0;
		checks_done = 0;
		sys_rst = 1;
		global_irq_enable = 0;
		flash_selfprog_enable = 0;
		void'($urandom(32'hAE82ECFB));
		repeat (4) @(negedge clock);
		check("irq_rst", {7'h00, ready_irq}, 8'h00);
		sys_rst = 0;
		cpu.rd(IDX_DATA, v);
		check("data_rst", v, DATA_RESET);
		cpu.wr(IDX_ADDR_HIGH, 8'hFF);
		cpu.rd(IDX_ADDR_HIGH, v);
		check("ahigh", v, 8'h03);
		cpu.wr(IDX_CONTROL, 8'hF0);
		cpu.rd(IDX_CONTROL, v);
		check("ctl_hi", v, 8'h00);
		for (int i = 0; i < 8; i++) begin
			al[i] = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom_range(1023));
			write_byte(al[i], 8'($urandom));
		end
		for (int i = 0; i < 8; i++)
			read_byte(al[i]);
		cpu.wr(IDX_CONTROL, 8'h02);
		refused();
		cpu.wr(IDX_CONTROL, 8'h06);
		refused();
		cpu.wr(IDX_CONTROL, 8'h04);
		cpu.rd(IDX_CONTROL, v);
		check("mwe_set", v, 8'h04);
		repeat (6) @(negedge clock);
		cpu.rd(IDX_CONTROL, v);
		check("mwe_clr", v, 8'h00);
		cpu.wr(IDX_CONTROL, 8'h02);
		refused();
		flash_selfprog_enable = 1;
		arm(8'h00);
		refused();
		flash_selfprog_enable = 0;
		read_byte(al[7]);
		global_irq_enable = 1;
		d = 8'($urandom);
		cpu.wr(IDX_DATA, d);
		cpu.wr(IDX_CONTROL, 8'h08);
		@(negedge clock);
		check("irq_on", {7'h00, ready_irq}, 8'h01);
		arm(8'h08);
		@(negedge clock);
		check("irq_busy", {7'h00, ready_irq}, 8'h00);
		cpu.wr(IDX_ADDR_LOW, ~al[7][7:0]);
		cpu.wr(IDX_CONTROL, 8'h0B);
		cpu.rd(IDX_ADDR_LOW, v);
		check("addr_hold", v, al[7][7:0]);
		cpu.rd(IDX_DATA, v);
		check("rd_ignored", v, d);
		wait_idle(n);
		mem[al[7]] = d;
		@(negedge clock);
		check("irq_idle", {7'h00, ready_irq}, 8'h01);
		global_irq_enable = 0;
		repeat (2) @(negedge clock);
		check("irq_glob", {7'h00, ready_irq}, 8'h00);
		d = 8'($urandom);
		cpu.wr(IDX_DATA, d);
		arm(8'h00);
		sys_rst = 1;
		repeat (2) @(negedge clock);
		sys_rst = 0;
		wait_idle(n);
		mem[al[7]] = d;
		read_byte(al[7]);
		close_out();
	end

	initial begin
		#3_000_000;
		bad_count++;
		close_out();
	end
endmodule
